// ===== dv/sbla_arbiter_checker.sv
`timescale 1ns/10ps
module sbla_arbiter_checker
    import sbla_pkg::*;
#(
    parameter int N_DEV = SBLA_N_DEV,
    parameter int FRAME_CYC = SBLA_FRAME_CYC,
    parameter int BUSY_CYC = SBLA_BUSY_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Device side
    input wire logic [N_DEV-1:0] dev_req_pin,
    input wire logic [N_DEV-1:0] dev_grant,
    input wire logic [N_DEV-1:0] remote_off,
    // Loop enables and bus drive
    input wire logic bus_dout_oe,
    input wire logic local_loop_rx_enable,
    input wire logic line_loop_rx_enable,
    input wire logic local_loop_tx_enable,
    input wire logic line_loop_tx_enable
);
    logic [15:0] gcnt_ff;
    logic [15:0] lgap_ff;
    logic [3:0] ens;
    assign ens = {local_loop_rx_enable, line_loop_rx_enable,
        local_loop_tx_enable, line_loop_tx_enable};
    // Length of the current grant frame
    always_ff @(posedge ref_clk) begin
        if (!rstn || dev_grant == '0) gcnt_ff <= 16'h0000;
        else gcnt_ff <= gcnt_ff + 16'h0001;
    end
    // Quiet time since local enable; saturates so reset never fires it
    always_ff @(posedge ref_clk) begin
        if (!rstn) lgap_ff <= 16'hFFFF;
        else if (local_loop_rx_enable) lgap_ff <= 16'h0000;
        else if (lgap_ff != 16'hFFFF) lgap_ff <= lgap_ff + 16'h0001;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_single_enable: assert property ($onehot0(ens))
        else $error("two loop enables at once");
    a_grant_onehot: assert property ($onehot0(dev_grant))
        else $error("grant not one-hot");
    a_grant_has_req: assert property ($rose(|dev_grant) && $past(rstn)
        |-> (dev_grant & $past(dev_req_pin, 3)) != '0)
        else $error("grant without request");
    a_frame_length: assert property ($fell(|dev_grant) && $past(rstn)
        |-> gcnt_ff == FRAME_CYC)
        else $error("grant frame length wrong");
    a_rx_has_grant: assert property (
        (local_loop_rx_enable || line_loop_rx_enable) |-> dev_grant != '0)
        else $error("rx enable without grant");
    a_status_no_rx: assert property (dev_grant[SBLA_STATUS_DEV]
        |-> !local_loop_rx_enable && !line_loop_rx_enable)
        else $error("status char sent to processor");
    a_bypass_no_rx: assert property (dev_grant[SBLA_BYPASS_DEV]
        |-> !local_loop_rx_enable && !line_loop_rx_enable)
        else $error("bypass char sent to processor");
    a_grant_not_off: assert property ($rose(|dev_grant) && $past(rstn)
        |-> (dev_grant & $past(remote_off)) == '0)
        else $error("remote-off device granted");
    a_local_rest: assert property (
        $rose(local_loop_rx_enable) && $past(rstn) |-> lgap_ff >= BUSY_CYC)
        else $error("local loop reused while busy");
    a_tx_drives_bus: assert property (bus_dout_oe ==
        (local_loop_tx_enable || line_loop_tx_enable))
        else $error("bus drive and tx enable disagree");
endmodule

bind sbla_arbiter sbla_arbiter_checker #(.N_DEV(N_DEV),
    .FRAME_CYC(FRAME_CYC), .BUSY_CYC(BUSY_CYC)) u_chk (
    .ref_clk, .rstn, .dev_req_pin, .dev_grant, .remote_off, .bus_dout_oe,
    .local_loop_rx_enable, .line_loop_rx_enable, .local_loop_tx_enable,
    .line_loop_tx_enable
);

// ===== dv/sbla_dev_model.sv
`timescale 1ns/10ps
module sbla_dev_model
    import sbla_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Scenario control
    input wire logic [SBLA_N_DEV-1:0] want,
    input wire logic [SBLA_N_DEV-1:0] hold_busy,
    input wire logic slow,
    // Bus side
    input wire logic [SBLA_N_DEV-1:0] dev_grant,
    output logic [SBLA_N_DEV-1:0] dev_req_pin,
    output logic [SBLA_N_DEV-1:0] dev_busy_pin,
    output logic [7:0] bus_din
);
    logic [3:0] cnt [SBLA_N_DEV];
    logic [SBLA_N_DEV-1:0] seen;

    initial begin
        dev_req_pin = '0;
        dev_busy_pin = '0;
        bus_din = 8'h00;
        seen = '0;
        foreach (cnt[i]) cnt[i] = 4'h0;
    end

    // Char is {device, count}; slow devices drive one cycle late
    always @(posedge ref_clk) begin
        dev_busy_pin <= hold_busy;
        dev_req_pin <= want & ~dev_grant;
        seen <= dev_grant;
        bus_din <= ~bus_din;
        for (int i = 0; i < SBLA_N_DEV; i++) begin
            if (dev_grant[i] && (!slow || seen[i]))
                bus_din <= {i[3:0], cnt[i]};
            if (seen[i] && !dev_grant[i])
                cnt[i] <= cnt[i] + 4'h1;
        end
    end
endmodule

// ===== dv/test_serial_bus_loop_arbiter.sv
`timescale 1ns/10ps
module test_serial_bus_loop_arbiter
    import sbla_pkg::*;
;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [5:0] dev_req_pin, dev_busy_pin, dev_grant, remote_off;
    logic [7:0] bus_din, bus_dout;
    logic bus_dout_oe, proc_loop_sel;
    logic local_loop_rx_enable, line_loop_rx_enable;
    logic local_loop_tx_enable, line_loop_tx_enable;
    logic [3:0] cass_ctrl;
    logic [5:0] want = 6'h00;
    logic [5:0] hold_busy = 6'h00;
    logic slow = 1'b0;
    int err_count = 0;
    int n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    // Short frame and busy time keep the run brief
    sbla_arbiter #(.FRAME_CYC(6), .BUSY_CYC(15)) dut (
        .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .dev_req_pin, .dev_busy_pin, .dev_grant, .bus_din,
        .bus_dout, .bus_dout_oe, .local_loop_rx_enable,
        .line_loop_rx_enable, .local_loop_tx_enable,
        .line_loop_tx_enable, .proc_loop_sel, .remote_off, .cass_ctrl
    );
    sbla_dev_model peer (
        .ref_clk, .want, .hold_busy, .slow, .dev_grant, .dev_req_pin,
        .dev_busy_pin, .bus_din
    );

    task final_report();
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rchk(input string what, input logic [7:0] a,
        input logic [31:0] exp, input logic [31:0] msk);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp & msk, reg_rdata & msk);
    endtask
    // Waits for a grant, checks it, then waits for its frame to close
    task grant(input logic [5:0] g, input logic [1:0] e);
        int k;
        k = 0;
        while (dev_grant === 6'h00 && k < 400) begin
            @(posedge ref_clk);
            #1 k++;
        end
        chk("grant", {26'h0, g}, {26'h0, dev_grant});
        chk("rx enables", {30'h0, e},
            {30'h0, local_loop_rx_enable, line_loop_rx_enable});
        while (dev_grant !== 6'h00 && k < 400) begin
            @(posedge ref_clk);
            #1 k++;
        end
        chk("close", 0, {26'h0, dev_grant});
        if (k >= 400) final_report();
    endtask

    task idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1 if (dev_grant !== 6'h00) chk("idle", 0, {26'h0, dev_grant});
        end
    endtask

    task s_tx(input logic lp, input logic [7:0] c);
        int k;
        k = 0;
        wr(SBLA_OFS_TX, {23'h0, lp, c});
        while ((lp ? line_loop_tx_enable : local_loop_tx_enable) !== 1'b1
            && k < 400) begin
            @(posedge ref_clk);
            #1 k++;
        end
        chk("tx", {22'h0, 1'b1, lp, c},
            {22'h0, bus_dout_oe, line_loop_tx_enable, bus_dout});
        if (k >= 400) final_report();
    endtask

    task s_regs();
        rchk("ctrl rst", SBLA_OFS_CTRL, 32'h0, ALL);
        rchk("status rst", SBLA_OFS_STAT, 32'h100, ALL);
        rchk("unmapped", 8'h20, 32'h0, ALL);
        wr(SBLA_OFS_CTRL, 32'hA3);
        wr(SBLA_OFS_ROFF, 32'h24);
        @(posedge ref_clk);
        #1 chk("ctrl pins", 32'h1A, {27'h0, proc_loop_sel, cass_ctrl});
        chk("roff pins", 32'h24, {26'h0, remote_off});
        wr(SBLA_OFS_ROFF, 32'h0);
        wr(SBLA_OFS_CTRL, 32'h1);
        wr(SBLA_OFS_MODE, 32'h199);
        rchk("mode", SBLA_OFS_MODE, 32'h199, ALL);
    endtask

    task s_prio();
        want <= 6'h05;
        grant(6'h01, 2'b10);
        want <= 6'h04;
        grant(6'h04, 2'b10);
        want <= 6'h00;
        rchk("lrx first", SBLA_OFS_LRX, 32'h100, ALL);
        rchk("lrx second", SBLA_OFS_LRX, 32'h120, ALL);
        rchk("lrx empty", SBLA_OFS_LRX, 32'h0, 32'h100);
    endtask

    // Local busy outlasts two frames, so the line device slips in
    task s_loops();
        idle(12);
        want <= 6'h09;
        grant(6'h01, 2'b10);
        grant(6'h08, 2'b01);
        grant(6'h01, 2'b10);
        want <= 6'h00;
        rchk("lrx a", SBLA_OFS_LRX, 32'h101, ALL);
        rchk("lrx b", SBLA_OFS_LRX, 32'h102, ALL);
        rchk("nrx", SBLA_OFS_NRX, 32'h130, ALL);
    endtask

    task s_special();
        want <= 6'h02;
        grant(6'h02, 2'b00);
        want <= 6'h00;
        rchk("cass", SBLA_OFS_CASS, 32'h110, ALL);
        rchk("cass cleared", SBLA_OFS_CASS, 32'h0, 32'h100);
        want <= 6'h10;
        grant(6'h10, 2'b00);
        want <= 6'h00;
        rchk("no capture", SBLA_OFS_STAT, 32'h0, 32'h30);
    endtask

    task s_block();
        wr(SBLA_OFS_ROFF, 32'h1);
        want <= 6'h01;
        idle(60);
        wr(SBLA_OFS_ROFF, 32'h0);
        grant(6'h01, 2'b10);
        hold_busy <= 6'h04;
        want <= 6'h04;
        idle(60);
        hold_busy <= 6'h00;
        grant(6'h04, 2'b10);
        want <= 6'h00;
        rchk("lrx c", SBLA_OFS_LRX, 32'h103, ALL);
        rchk("lrx d", SBLA_OFS_LRX, 32'h121, ALL);
    endtask

    // Full buffer holds off a slow device until software drains it
    task s_fill();
        slow <= 1'b1;
        want <= 6'h01;
        grant(6'h01, 2'b10);
        grant(6'h01, 2'b10);
        idle(80);
        rchk("fill a", SBLA_OFS_LRX, 32'h104, ALL);
        grant(6'h01, 2'b10);
        want <= 6'h00;
        slow <= 1'b0;
        rchk("fill b", SBLA_OFS_LRX, 32'h105, ALL);
        rchk("fill c", SBLA_OFS_LRX, 32'h106, ALL);
        rchk("fill empty", SBLA_OFS_LRX, 32'h0, 32'h100);
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        s_regs();
        s_prio();
        s_loops();
        s_special();
        s_block();
        s_fill();
        s_tx(1'b1, 8'h55);
        s_tx(1'b0, 8'hAA);
        final_report();
    end
endmodule

// ===== src/sbla_arbiter.sv
// Summary of operation
// - Separate local and line receive enables tell processor the source loop.
// - Local and line characters land in two independent input buffers.
// - One output buffer transmits on one chosen loop at a time.
// - Upper cassette status character is captured by the arbiter itself.
// - Recorder print buffer transfers bypass the processor; others pass through.
// - All other bus characters go to the processor for mode-based action.
// - Each device's on-line, local, off and busy state steers grants.
// - Highest priority requester wins, only if its loop is idle.
// - Local winner plus local input buffer enabled for one frame.
// - After a grant the loop is busy; other loop may still be served.
// - Processor drives an output naming the loop it works on.
// - Processor drives remote-off lines for devices and cassette controls.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module sbla_arbiter
    import sbla_pkg::*;
#(
    parameter int N_DEV = SBLA_N_DEV,
    parameter logic [SBLA_IDX_W*N_DEV-1:0] PRIO_ORDER =
        SBLA_PRIO_DEF[SBLA_IDX_W*N_DEV-1:0],
    parameter int STATUS_DEV = SBLA_STATUS_DEV,
    parameter int BYPASS_DEV = SBLA_BYPASS_DEV,
    parameter int FRAME_CYC = SBLA_FRAME_CYC,
    parameter int BUSY_CYC = SBLA_BUSY_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Device requests and state pins
    input wire logic [N_DEV-1:0] dev_req_pin,
    input wire logic [N_DEV-1:0] dev_busy_pin,
    output logic [N_DEV-1:0] dev_grant,
    // Serial data bus character lanes
    input wire logic [7:0] bus_din,
    output logic [7:0] bus_dout,
    output logic bus_dout_oe,
    // Loop enables
    output logic local_loop_rx_enable,
    output logic line_loop_rx_enable,
    output logic local_loop_tx_enable,
    output logic line_loop_tx_enable,
    // Processor control lines
    output logic proc_loop_sel,
    output logic [N_DEV-1:0] remote_off,
    output logic [SBLA_CASS_W-1:0] cass_ctrl
);

    localparam int IW = SBLA_IDX_W;
    localparam int FW = $clog2(FRAME_CYC + 1);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYC - 1);
    localparam int SW = 2 * N_DEV + SBLA_CH_W;

    generate
        if (N_DEV < 2 || N_DEV > SBLA_MAX_DEV) begin : g_chk_n
            $error("sbla_arbiter: N_DEV out of range");
        end
        if (STATUS_DEV >= N_DEV || BYPASS_DEV >= N_DEV ||
            STATUS_DEV == BYPASS_DEV) begin : g_chk_sp
            $error("sbla_arbiter: bad special device index");
        end
        if (FRAME_CYC < 2) begin : g_chk_f
            $error("sbla_arbiter: FRAME_CYC must be at least 2");
        end
    endgenerate

    // Pin synchronisers
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [N_DEV-1:0] req_s;
    logic [N_DEV-1:0] busy_s;
    logic [7:0] din_s;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {dev_req_pin, dev_busy_pin, bus_din};
            sync2_ff <= sync1_ff;
        end
    end

    assign req_s = sync2_ff[SW-1 -: N_DEV];
    assign busy_s = sync2_ff[SBLA_CH_W +: N_DEV];
    assign din_s = sync2_ff[SBLA_CH_W-1:0];

    // Software registers
    logic [7:0] ctrl_ff;
    logic [2*N_DEV-1:0] mode_ff;
    logic [N_DEV-1:0] roff_ff;
    sbla_tx_t tx_ff;
    logic tx_pend_ff;
    logic [7:0] cass_stat_ff;
    logic cass_vld_ff;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_roff;
    logic wr_tx;
    logic rd_cass;
    logic rd_lrx;
    logic rd_nrx;

    assign wr_ctrl = reg_wr && reg_addr == SBLA_OFS_CTRL;
    assign wr_mode = reg_wr && reg_addr == SBLA_OFS_MODE;
    assign wr_roff = reg_wr && reg_addr == SBLA_OFS_ROFF;
    assign wr_tx = reg_wr && reg_addr == SBLA_OFS_TX;
    assign rd_cass = reg_rd && reg_addr == SBLA_OFS_CASS;
    assign rd_lrx = reg_rd && reg_addr == SBLA_OFS_LRX;
    assign rd_nrx = reg_rd && reg_addr == SBLA_OFS_NRX;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_ff <= SBLA_CTRL_RST;
            mode_ff <= SBLA_MODE_RST[2*N_DEV-1:0];
            roff_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata[7:0];
            end
            if (wr_mode) begin
                mode_ff <= reg_wdata[2*N_DEV-1:0];
            end
            if (wr_roff) begin
                roff_ff <= reg_wdata[N_DEV-1:0];
            end
        end
    end

    // Per-device eligibility
    logic [N_DEV-1:0] dev_line;
    logic [N_DEV-1:0] dev_path_rdy;
    logic [N_DEV-1:0] elig;
    logic lbusy;
    logic nbusy;
    logic lbuf_rdy;
    logic nbuf_rdy;

    genvar gi;
    generate
        for (gi = 0; gi < N_DEV; gi++) begin : g_dev
            sbla_mode_t md;
            logic on;
            logic loop_free;
            assign md = sbla_mode_t'(mode_ff[2*gi +: 2]);
            assign on = (md == SBLA_MODE_LOCAL) ||
                (md == SBLA_MODE_LINE);
            assign dev_line[gi] = (md == SBLA_MODE_LINE);
            assign loop_free = dev_line[gi] ? !nbusy : !lbusy;
            // Full input buffer holds the device off rather than drop
            assign dev_path_rdy[gi] =
                (gi == STATUS_DEV || gi == BYPASS_DEV) ? 1'b1 :
                (dev_line[gi] ? nbuf_rdy : lbuf_rdy);
            assign elig[gi] = req_s[gi] && on && !busy_s[gi] &&
                !roff_ff[gi] && loop_free && dev_path_rdy[gi];
        end
    endgenerate

    // Fixed priority pick, rank 0 wins
    logic win_hit;
    logic [IW-1:0] win_idx;
    logic [IW-1:0] rank_idx;

    always_comb begin
        win_hit = 1'b0;
        win_idx = '0;
        rank_idx = '0;
        for (int r = N_DEV - 1; r >= 0; r--) begin
            rank_idx = PRIO_ORDER[r*IW +: IW];
            if (int'(rank_idx) < N_DEV && elig[rank_idx]) begin
                win_hit = 1'b1;
                win_idx = rank_idx;
            end
        end
    end

    // Enable time frame divider
    logic [FW-1:0] frame_cnt_ff;
    logic frame_tick;

    assign frame_tick = (frame_cnt_ff == FRAME_LAST);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            frame_cnt_ff <= '0;
        end else if (frame_tick) begin
            frame_cnt_ff <= '0;
        end else begin
            frame_cnt_ff <= frame_cnt_ff + 1'b1;
        end
    end

    // Grant sequencer
    sbla_state_t state_ff;
    logic [IW-1:0] gnt_idx_ff;
    logic gnt_line_ff;
    logic tx_go;
    logic frame_end;
    logic gnt_status;
    logic gnt_bypass;

    assign tx_go = ctrl_ff[SBLA_CTRL_EN] && tx_pend_ff &&
        (tx_ff.loop ? !nbusy : !lbusy);
    assign frame_end = frame_tick && (state_ff != SBLA_ST_IDLE);
    assign gnt_status = (int'(gnt_idx_ff) == STATUS_DEV);
    assign gnt_bypass = (int'(gnt_idx_ff) == BYPASS_DEV);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_ff <= SBLA_ST_IDLE;
            gnt_idx_ff <= '0;
            gnt_line_ff <= 1'b0;
        end else if (frame_tick) begin
            unique case (state_ff)
                SBLA_ST_IDLE: begin
                    // Devices outrank the processor's own output
                    if (ctrl_ff[SBLA_CTRL_EN] && win_hit) begin
                        state_ff <= SBLA_ST_DEV;
                        gnt_idx_ff <= win_idx;
                        gnt_line_ff <= dev_line[win_idx];
                    end else if (tx_go) begin
                        state_ff <= SBLA_ST_TX;
                        gnt_line_ff <= tx_ff.loop;
                    end
                end
                SBLA_ST_DEV, SBLA_ST_TX: begin
                    state_ff <= SBLA_ST_IDLE;
                end
                default: begin
                    state_ff <= SBLA_ST_IDLE;
                end
            endcase
        end
    end

    // Enables for the frame, one loop only
    logic [N_DEV-1:0] win_onehot;
    logic win_line;
    logic win_rx;

    assign win_onehot = N_DEV'(1) << win_idx;
    assign win_line = dev_line[win_idx];
    assign win_rx = (int'(win_idx) != STATUS_DEV) &&
        (int'(win_idx) != BYPASS_DEV);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dev_grant <= '0;
            local_loop_rx_enable <= 1'b0;
            line_loop_rx_enable <= 1'b0;
            local_loop_tx_enable <= 1'b0;
            line_loop_tx_enable <= 1'b0;
            bus_dout <= '0;
            bus_dout_oe <= 1'b0;
        end else if (frame_tick) begin
            dev_grant <= '0;
            local_loop_rx_enable <= 1'b0;
            line_loop_rx_enable <= 1'b0;
            local_loop_tx_enable <= 1'b0;
            line_loop_tx_enable <= 1'b0;
            bus_dout_oe <= 1'b0;
            if (state_ff == SBLA_ST_IDLE) begin
                if (ctrl_ff[SBLA_CTRL_EN] && win_hit) begin
                    dev_grant <= win_onehot;
                    local_loop_rx_enable <= win_rx && !win_line;
                    line_loop_rx_enable <= win_rx && win_line;
                end else if (tx_go) begin
                    local_loop_tx_enable <= !tx_ff.loop;
                    line_loop_tx_enable <= tx_ff.loop;
                    bus_dout <= tx_ff.data;
                    bus_dout_oe <= 1'b1;
                end
            end
        end
    end

    // Loop busy timers, started as each frame closes
    logic lbusy_go;
    logic nbusy_go;

    assign lbusy_go = frame_end && !gnt_line_ff;
    assign nbusy_go = frame_end && gnt_line_ff;

    sbla_busy_tmr #(
        .CYC(BUSY_CYC)
    ) u_local_busy (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(lbusy_go),
        .busy(lbusy)
    );

    sbla_busy_tmr #(
        .CYC(BUSY_CYC)
    ) u_line_busy (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(nbusy_go),
        .busy(nbusy)
    );

    // Character capture at the close of a device frame
    logic cap;
    logic lpush;
    logic npush;
    logic lvld;
    logic nvld;
    logic [7:0] ldata;
    logic [7:0] ndata;

    assign cap = frame_end && (state_ff == SBLA_ST_DEV);
    assign lpush = cap && !gnt_status && !gnt_bypass && !gnt_line_ff;
    assign npush = cap && !gnt_status && !gnt_bypass && gnt_line_ff;

    sbla_buf2 #(
        .W(SBLA_CH_W)
    ) u_local_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(lpush),
        .in_ready(lbuf_rdy),
        .in_data(din_s),
        .out_valid(lvld),
        .out_ready(rd_lrx),
        .out_data(ldata)
    );

    sbla_buf2 #(
        .W(SBLA_CH_W)
    ) u_line_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(npush),
        .in_ready(nbuf_rdy),
        .in_data(din_s),
        .out_valid(nvld),
        .out_ready(rd_nrx),
        .out_data(ndata)
    );

    // Cassette status byte, kept away from the processor buffers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cass_stat_ff <= '0;
            cass_vld_ff <= 1'b0;
        end else if (cap && gnt_status) begin
            cass_stat_ff <= din_s;
            cass_vld_ff <= 1'b1;
        end else if (rd_cass) begin
            cass_vld_ff <= 1'b0;
        end
    end

    // Output buffer; a write while pending is dropped
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tx_ff <= '0;
            tx_pend_ff <= 1'b0;
        end else if (wr_tx && !tx_pend_ff) begin
            tx_ff.data <= reg_wdata[SBLA_CH_W-1:0];
            tx_ff.loop <= reg_wdata[SBLA_TX_LOOP];
            tx_pend_ff <= 1'b1;
        end else if (frame_tick && state_ff == SBLA_ST_IDLE &&
                     !(ctrl_ff[SBLA_CTRL_EN] && win_hit) && tx_go) begin
            tx_pend_ff <= 1'b0;
        end
    end

    // Processor control lines
    assign proc_loop_sel = ctrl_ff[SBLA_CTRL_LOOP];
    assign remote_off = roff_ff;
    assign cass_ctrl = ctrl_ff[SBLA_CTRL_CASS +: SBLA_CASS_W];

    // Read port, data valid only in the cycle after the strobe
    logic [31:0] rd_mux;
    logic [31:0] stat_word;

    assign stat_word = 32'({state_ff, 2'h0, nvld, lvld, cass_vld_ff,
        tx_pend_ff, nbusy, lbusy});

    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            SBLA_OFS_CTRL: rd_mux = 32'(ctrl_ff);
            SBLA_OFS_MODE: rd_mux = 32'(mode_ff);
            SBLA_OFS_ROFF: rd_mux = 32'(roff_ff);
            SBLA_OFS_STAT: rd_mux = stat_word;
            SBLA_OFS_CASS: rd_mux = 32'({cass_vld_ff, cass_stat_ff});
            SBLA_OFS_TX: rd_mux = 32'(tx_ff);
            SBLA_OFS_LRX: rd_mux = 32'({lvld, ldata});
            SBLA_OFS_NRX: rd_mux = 32'({nvld, ndata});
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ===== src/sbla_buf2.sv
`timescale 1ns/10ps
module sbla_buf2
    import sbla_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] d0_ff;
    logic [W-1:0] d1_ff;
    logic [1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = d0_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_ff <= 2'h0;
        end else begin
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // Head always sits in d0 so the read data come from a flop
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            d0_ff <= '0;
            d1_ff <= '0;
        end else if (pop) begin
            d0_ff <= (cnt_ff == 2'h1) ? in_data : d1_ff;
            if (push && cnt_ff == 2'h2) begin
                d1_ff <= in_data;
            end
        end else if (push) begin
            if (cnt_ff == 2'h0) begin
                d0_ff <= in_data;
            end else begin
                d1_ff <= in_data;
            end
        end
    end

endmodule

// ===== src/sbla_busy_tmr.sv
`timescale 1ns/10ps
module sbla_busy_tmr
    import sbla_pkg::*;
#(
    parameter int CYC = SBLA_BUSY_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Control
    input wire logic start,
    output logic busy
);

    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYC);

    logic [CW-1:0] cnt_ff;

    generate
        if (CYC < 1) begin : g_chk
            $error("sbla_busy_tmr: CYC must be at least 1");
        end
    endgenerate

    assign busy = (cnt_ff != '0);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (start) begin
            cnt_ff <= LOAD;
        end else if (busy) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

endmodule

// ===== src/sbla_pkg.sv
package sbla_pkg;

    // Clock and timing
    localparam int SBLA_CLK_NS = 50;
    localparam int SBLA_FRAME_NS = 1000;
    localparam int SBLA_FRAME_CYC =
        (SBLA_FRAME_NS + SBLA_CLK_NS - 1) / SBLA_CLK_NS;
    localparam int SBLA_BUSY_NS = 10000;
    localparam int SBLA_BUSY_CYC =
        (SBLA_BUSY_NS + SBLA_CLK_NS - 1) / SBLA_CLK_NS;

    // Devices and priority (rank 0 is highest)
    localparam int SBLA_N_DEV = 6;
    localparam int SBLA_MAX_DEV = 8;
    localparam int SBLA_IDX_W = 3;
    localparam logic [23:0] SBLA_PRIO_DEF = 24'hFAC688;
    localparam int SBLA_STATUS_DEV = 1;
    localparam int SBLA_BYPASS_DEV = 4;

    // Register byte offsets
    localparam logic [7:0] SBLA_OFS_CTRL = 8'h00;
    localparam logic [7:0] SBLA_OFS_MODE = 8'h04;
    localparam logic [7:0] SBLA_OFS_ROFF = 8'h08;
    localparam logic [7:0] SBLA_OFS_STAT = 8'h0C;
    localparam logic [7:0] SBLA_OFS_CASS = 8'h10;
    localparam logic [7:0] SBLA_OFS_TX = 8'h14;
    localparam logic [7:0] SBLA_OFS_LRX = 8'h18;
    localparam logic [7:0] SBLA_OFS_NRX = 8'h1C;

    // Field positions
    localparam int SBLA_CTRL_EN = 0;
    localparam int SBLA_CTRL_LOOP = 1;
    localparam int SBLA_CTRL_CASS = 4;
    localparam int SBLA_CASS_W = 4;
    localparam int SBLA_ST_LBUSY = 0;
    localparam int SBLA_ST_NBUSY = 1;
    localparam int SBLA_ST_TXP = 2;
    localparam int SBLA_ST_SVLD = 3;
    localparam int SBLA_ST_LVLD = 4;
    localparam int SBLA_ST_NVLD = 5;
    localparam int SBLA_ST_FSM = 8;
    localparam int SBLA_CH_W = 8;
    localparam int SBLA_TX_LOOP = 8;
    localparam int SBLA_RX_VLD = 8;

    // Reset values
    localparam logic [7:0] SBLA_CTRL_RST = 8'h00;
    localparam logic [15:0] SBLA_MODE_RST = 16'h0000;

    // Per-device mode codes
    typedef enum logic [1:0] {
        SBLA_MODE_OFF = 2'h0,
        SBLA_MODE_LOCAL = 2'h1,
        SBLA_MODE_LINE = 2'h2
    } sbla_mode_t;

    typedef enum logic [2:0] {
        SBLA_ST_IDLE = 3'b001,
        SBLA_ST_DEV = 3'b010,
        SBLA_ST_TX = 3'b100
    } sbla_state_t;

    // Character queued for the output buffer
    typedef struct packed {
        logic loop;
        logic [7:0] data;
    } sbla_tx_t;

endpackage
